// file: rtl/asw_pkg.sv
// Package: constants for the axis status word reporter
package asw_pkg;
	// Input word indices within one axis block
	localparam logic [1:0] IDX_POS_LO   = 2'h0;
	localparam logic [1:0] IDX_POS_HI   = 2'h1;
	localparam logic [1:0] IDX_DONE_NUM = 2'h2;
	localparam logic [1:0] IDX_STATUS   = 2'h3;
	// Status word bit positions
	localparam int B_EMG    = 15;
	localparam int B_STBY   = 14;
	localparam int B_SECOND_RANGE_FLAG  = 13;
	localparam int B_FIRST_RANGE_FLAG  = 12;
	localparam int B_ENTRY_RANGE_FLAG  = 11;
	localparam int B_UNUSED_HI = 10;
	localparam int B_UNUSED_LO = 9;
	localparam int B_MOTION_END_FLAG   = 8;
	localparam int B_LIGHT  = 7;
	localparam int B_LOAD   = 6;
	localparam int B_PMISS  = 5;
	localparam int B_SERVO  = 4;
	localparam int B_FAULT  = 3;
	localparam int B_MOVE   = 2;
	localparam int B_HOME   = 1;
	localparam int B_PDONE  = 0;
	// Reset values
	localparam logic [31:0] RST_POS    = 32'h0000_0000;
	localparam logic [15:0] RST_NUM    = 16'h0000;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	// Motion tracker states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_MOVING = 4'h2,
		ST_DONE   = 4'h4,
		ST_FAILED = 4'h8
	} asw_motion_type;
endpackage

// file: rtl/asw_range_check.sv
// Range comparator: flags a signed position inside an inclusive window
`timescale 1ns/100ps
`default_nettype none
module asw_range_check #(
	parameter int WIDTH = 32
) (
	// Position and window limits
	input  wire logic [WIDTH-1:0] pos_i,
	input  wire logic [WIDTH-1:0] lo_i,
	input  wire logic [WIDTH-1:0] hi_i,
	// Result
	output logic                  inside_o
);
	// A one-bit window cannot hold a signed value
	if (WIDTH < 2) begin : g_bad_width
		$error("asw_range_check: WIDTH too small");
	end

	// Signed inclusive compare; an inverted window never matches
	always_comb begin
		inside_o = ($signed(pos_i) >= $signed(lo_i)) &&
			($signed(pos_i) <= $signed(hi_i));
	end
endmodule // asw_range_check
`default_nettype wire

// file: rtl/asw_reporter.sv
// Axis status word reporter: fills the host-facing position/status words
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1 - Current position word is 32-bit two's complement in 0.01 mm units.
// RQ2 - After reaching the positioning width, the reached number is shown.
// RQ3 - Number word reads zero before any move and while moving.
// RQ4 - While faulted, the number word carries the simple alarm code.
// RQ5 - Host reads the number word only after positioning done is set.
// RQ6 - Bit 15 set while an emergency stop is in effect.
// RQ7 - Bit 14 set while the controller stands by ready.
// RQ8 - Bit 13 set while position lies within the second range.
// RQ9 - Bit 12 set while position lies within the first range.
// RQ10 - Bit 11 set while position lies in the active entry's zone.
// RQ11 - Bit 8 set on positioning, homing or pressing end; cleared at start.
// RQ12 - Motion end flag held clear while the servo is off.
// RQ13 - Bit 7 set on overload warning or message-level error.
// RQ14 - Bit 6 follows the load output judgement.
// RQ15 - Bit 5 set when a pressing operation ends in a miss.
// RQ16 - Bit 4 set once operation standby is complete, servo on.
// RQ17 - Bit 3 set for the whole time a fault is active.
// RQ18 - Bit 2 set for the whole time the axis moves.
// RQ19 - Bit 1 set at homing end, kept until home is lost; the code also clears it on a fault.
// RQ20 - Bit 0 set at positioning end, kept while stopped servo on.
// RQ21 - All flags are active high.
// RQ22 - Bits 10 and 9 read as zero.
module asw_reporter #(
	parameter int POS_W = 32,
	parameter int NUM_W = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// Axis state from the motion core
	input  wire logic [POS_W-1:0] position_i,
	input  wire logic             move_start_i,
	input  wire logic             in_pos_width_i,
	input  wire logic [NUM_W-1:0] target_num_i,
	input  wire logic             home_done_i,
	input  wire logic             home_lost_i,
	input  wire logic             push_end_i,
	input  wire logic             push_miss_i,
	input  wire logic             servo_on_i,
	input  wire logic             fault_i,
	input  wire logic [NUM_W-1:0] fault_code_i,
	input  wire logic             emg_stop_i,
	input  wire logic             standby_i,
	input  wire logic             overload_warn_i,
	input  wire logic             message_err_i,
	input  wire logic             load_ok_i,
	// Zone limits
	input  wire logic [POS_W-1:0] first_range_flag_lo_i,
	input  wire logic [POS_W-1:0] first_range_flag_hi_i,
	input  wire logic [POS_W-1:0] second_range_flag_lo_i,
	input  wire logic [POS_W-1:0] second_range_flag_hi_i,
	input  wire logic [POS_W-1:0] entry_range_flag_lo_i,
	input  wire logic [POS_W-1:0] entry_range_flag_hi_i,
	// Host input words, indexed read
	input  wire logic [1:0]       word_sel_i,
	output logic [15:0]           word_o,
	// Full words
	output logic [POS_W-1:0]      current_position_word_o,
	output logic [NUM_W-1:0]      completed_position_number_o,
	output logic [15:0]           axis_status_flags_o
);
	// Word layout is fixed by the host map; other widths cannot be served
	if (POS_W != 32) begin : g_bad_pos_w
		$error("asw_reporter: POS_W must be 32");
	end
	if (NUM_W != 16) begin : g_bad_num_w
		$error("asw_reporter: NUM_W must be 16");
	end

	// All assertions below share this clock and reset
	default clocking cb_asw @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	////////////////////////////////////////////////////////////////////
	// Zone comparators
	logic first_range_flag_hit;
	logic second_range_flag_hit;
	logic entry_range_flag_hit;

	asw_range_check #(.WIDTH(POS_W)) u_first_range_flag (
		.pos_i    (position_i),
		.lo_i     (first_range_flag_lo_i),
		.hi_i     (first_range_flag_hi_i),
		.inside_o (first_range_flag_hit)
	);
	asw_range_check #(.WIDTH(POS_W)) u_second_range_flag (
		.pos_i    (position_i),
		.lo_i     (second_range_flag_lo_i),
		.hi_i     (second_range_flag_hi_i),
		.inside_o (second_range_flag_hit)
	);
	asw_range_check #(.WIDTH(POS_W)) u_entry_range_flag (
		.pos_i    (position_i),
		.lo_i     (entry_range_flag_lo_i),
		.hi_i     (entry_range_flag_hi_i),
		.inside_o (entry_range_flag_hit)
	);

	////////////////////////////////////////////////////////////////////
	// Motion tracker state
	asw_pkg::asw_motion_type st_r;
	asw_pkg::asw_motion_type st_nxt;
	logic [NUM_W-1:0]        num_r;
	logic [NUM_W-1:0]        num_nxt;
	logic                    motion_end_flag_r;
	logic                    motion_end_flag_nxt;
	logic                    pdone_r;
	logic                    pdone_nxt;
	logic                    homing_done_flag_r;
	logic                    homing_done_flag_nxt;
	logic                    pmiss_r;
	logic                    pmiss_nxt;

	// Next state; a homing end in the same cycle as a move start still sets the motion end flag
	always_comb begin
		st_nxt    = st_r;
		num_nxt   = num_r;
		motion_end_flag_nxt  = motion_end_flag_r;
		pdone_nxt = pdone_r;
		homing_done_flag_nxt  = homing_done_flag_r;
		pmiss_nxt = pmiss_r;
		case (st_r)
			asw_pkg::ST_IDLE,
			asw_pkg::ST_DONE,
			asw_pkg::ST_FAILED: begin
				if (move_start_i) begin
					st_nxt    = asw_pkg::ST_MOVING;
					num_nxt   = '0; // RQ3
					motion_end_flag_nxt  = 1'b0; // RQ11
					pdone_nxt = 1'b0;
					pmiss_nxt = 1'b0;
				end
			end
			asw_pkg::ST_MOVING: begin
				if (push_end_i && push_miss_i) begin
					st_nxt    = asw_pkg::ST_FAILED;
					motion_end_flag_nxt  = 1'b1; // RQ11
					pmiss_nxt = 1'b1; // RQ15
				end else if (in_pos_width_i || push_end_i) begin
					st_nxt    = asw_pkg::ST_DONE;
					num_nxt   = target_num_i; // RQ2
					motion_end_flag_nxt  = 1'b1; // RQ11
					pdone_nxt = 1'b1; // RQ20
				end
			end
			default: begin
				st_nxt = asw_pkg::ST_IDLE;
			end
		endcase
		// Homing end sets both home and motion end flags
		if (home_done_i) begin
			homing_done_flag_nxt = 1'b1; // RQ19
			motion_end_flag_nxt = 1'b1; // RQ11
		end else if (home_lost_i || fault_i) begin
			homing_done_flag_nxt = 1'b0; // RQ19
		end
		// Positioning done only survives a stop while the servo stays on
		if (!servo_on_i) begin
			motion_end_flag_nxt  = 1'b0; // RQ12
			pdone_nxt = 1'b0; // RQ20
		end
	end

	// Register the tracker
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r    <= asw_pkg::ST_IDLE;
			num_r   <= asw_pkg::RST_NUM;
			motion_end_flag_r  <= 1'b0;
			pdone_r <= 1'b0;
			homing_done_flag_r  <= 1'b0;
			pmiss_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			num_r   <= num_nxt;
			motion_end_flag_r  <= motion_end_flag_nxt;
			pdone_r <= pdone_nxt;
			homing_done_flag_r  <= homing_done_flag_nxt;
			pmiss_r <= pmiss_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output words
	logic [POS_W-1:0] pos_nxt;
	logic [NUM_W-1:0] out_num_nxt;
	logic [15:0]      status_nxt;
	logic [15:0]      word_nxt;

	// Compose words; flags are plain active-high levels
	always_comb begin
		pos_nxt    = position_i; // RQ1
		out_num_nxt = fault_i ? fault_code_i : num_nxt; // RQ4
		status_nxt = asw_pkg::RST_STATUS;
		status_nxt[asw_pkg::B_EMG]   = emg_stop_i; // RQ6
		status_nxt[asw_pkg::B_STBY]  = standby_i; // RQ7
		status_nxt[asw_pkg::B_SECOND_RANGE_FLAG] = second_range_flag_hit; // RQ8
		status_nxt[asw_pkg::B_FIRST_RANGE_FLAG] = first_range_flag_hit; // RQ9
		status_nxt[asw_pkg::B_ENTRY_RANGE_FLAG] = entry_range_flag_hit; // RQ10
		status_nxt[asw_pkg::B_UNUSED_HI] = 1'b0; // RQ22
		status_nxt[asw_pkg::B_UNUSED_LO] = 1'b0; // RQ22
		status_nxt[asw_pkg::B_MOTION_END_FLAG]  = motion_end_flag_nxt; // RQ11
		status_nxt[asw_pkg::B_LIGHT] = overload_warn_i | message_err_i; // RQ13
		status_nxt[asw_pkg::B_LOAD]  = load_ok_i; // RQ14
		status_nxt[asw_pkg::B_PMISS] = pmiss_nxt; // RQ15
		status_nxt[asw_pkg::B_SERVO] = servo_on_i; // RQ16
		status_nxt[asw_pkg::B_FAULT] = fault_i; // RQ17
		status_nxt[asw_pkg::B_MOVE]  = (st_nxt == asw_pkg::ST_MOVING); // RQ18
		status_nxt[asw_pkg::B_HOME]  = homing_done_flag_nxt; // RQ19
		status_nxt[asw_pkg::B_PDONE] = pdone_nxt; // RQ20 RQ21
		case (word_sel_i)
			asw_pkg::IDX_POS_LO:   word_nxt = pos_nxt[15:0];
			asw_pkg::IDX_POS_HI:   word_nxt = pos_nxt[31:16];
			asw_pkg::IDX_DONE_NUM: word_nxt = out_num_nxt;
			asw_pkg::IDX_STATUS:   word_nxt = status_nxt;
			default:               word_nxt = 16'h0000;
		endcase
	end

	// Register all words so the full-word outputs form one coherent snapshot; word_o gives the host one word per read
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			current_position_word_o     <= asw_pkg::RST_POS;
			completed_position_number_o <= asw_pkg::RST_NUM;
			axis_status_flags_o         <= asw_pkg::RST_STATUS;
			word_o                      <= 16'h0000;
		end else begin
			current_position_word_o     <= pos_nxt;
			completed_position_number_o <= out_num_nxt;
			axis_status_flags_o         <= status_nxt;
			word_o                      <= word_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions; every output word lags its inputs by one registered edge
	a_pos_follows: assert property (1'b1 |=> // RQ1
		current_position_word_o == $past(position_i))
		else $error("position word does not follow input");
	a_num_reached: assert property ( // RQ2
		(st_r == asw_pkg::ST_MOVING && in_pos_width_i && !push_end_i &&
		!fault_i) |=> completed_position_number_o == $past(target_num_i))
		else $error("reached number not shown");
	a_num_zero_move: assert property ( // RQ3
		(axis_status_flags_o[asw_pkg::B_MOVE] &&
		!axis_status_flags_o[asw_pkg::B_FAULT])
		|-> completed_position_number_o == 16'h0000)
		else $error("number nonzero while moving");
	a_num_alarm: assert property (fault_i |=> // RQ4
		completed_position_number_o == $past(fault_code_i))
		else $error("alarm code not shown");
	a_emg_bit: assert property (1'b1 |=> // RQ6
		axis_status_flags_o[asw_pkg::B_EMG] == $past(emg_stop_i))
		else $error("emergency flag wrong");
	a_stby_bit: assert property (1'b1 |=> // RQ7
		axis_status_flags_o[asw_pkg::B_STBY] == $past(standby_i))
		else $error("standby flag wrong");
	a_motion_end_flag_servo: assert property (!servo_on_i |=> // RQ12
		!axis_status_flags_o[asw_pkg::B_MOTION_END_FLAG] &&
		!axis_status_flags_o[asw_pkg::B_PDONE])
		else $error("motion end set with servo off");
	a_motion_end_flag_start: assert property ( // RQ11
		(move_start_i && st_r != asw_pkg::ST_MOVING && !home_done_i)
		|=> !axis_status_flags_o[asw_pkg::B_MOTION_END_FLAG] &&
		axis_status_flags_o[asw_pkg::B_MOVE])
		else $error("motion end not cleared at start");
	a_light_bit: assert property ( // RQ13
		(overload_warn_i || message_err_i)
		|=> axis_status_flags_o[asw_pkg::B_LIGHT])
		else $error("light fault flag missing");
	a_load_bit: assert property (1'b1 |=> // RQ14
		axis_status_flags_o[asw_pkg::B_LOAD] == $past(load_ok_i))
		else $error("load judgement flag wrong");
	a_miss_nodone: assert property ( // RQ15 RQ20
		(st_r == asw_pkg::ST_MOVING && push_end_i && push_miss_i)
		|=> axis_status_flags_o[asw_pkg::B_PMISS] &&
		!axis_status_flags_o[asw_pkg::B_PDONE])
		else $error("push miss handling wrong");
	a_servo_bit: assert property (1'b1 |=> // RQ16
		axis_status_flags_o[asw_pkg::B_SERVO] == $past(servo_on_i))
		else $error("servo flag wrong");
	a_fault_bit: assert property (1'b1 |=> // RQ17
		axis_status_flags_o[asw_pkg::B_FAULT] == $past(fault_i))
		else $error("fault flag wrong");
	a_move_bit: assert property ( // RQ18
		(move_start_i && st_r != asw_pkg::ST_MOVING)
		|=> axis_status_flags_o[asw_pkg::B_MOVE])
		else $error("moving flag not set at start");
	a_home_keep: assert property ( // RQ19
		(axis_status_flags_o[asw_pkg::B_HOME] && !home_lost_i && !fault_i)
		|=> axis_status_flags_o[asw_pkg::B_HOME])
		else $error("home flag dropped");
	a_pdone_keep: assert property ( // RQ20
		(axis_status_flags_o[asw_pkg::B_PDONE] && servo_on_i &&
		!move_start_i) |=> axis_status_flags_o[asw_pkg::B_PDONE])
		else $error("positioning done dropped at rest");
	a_unused_zero: assert property ( // RQ22
		axis_status_flags_o[10:9] == 2'h0)
		else $error("unused bits nonzero");
	c_move_done: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r == asw_pkg::ST_MOVING ##1 st_r == asw_pkg::ST_DONE);
	c_push_fail: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r == asw_pkg::ST_MOVING ##1 st_r == asw_pkg::ST_FAILED);
	c_home_done: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		home_done_i ##1 axis_status_flags_o[asw_pkg::B_HOME]);
	c_alarm_code: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_i && fault_code_i != 16'h0000);
endmodule // asw_reporter
`default_nettype wire

// file: dv/asw_host_model.sv
// Host model: fieldbus master reading one axis block word by word
`timescale 1ns/100ps
`default_nettype none
module asw_host_model (
	// Clock
	input  wire logic        clk_i,
	// Read port toward the reporter
	output logic [1:0]       word_sel_o,
	input  wire logic [15:0] word_i
);
	initial word_sel_o = 2'h0;
	// Select on a falling edge; the word is registered, so take it a cycle on
	task automatic read_word(input logic [1:0] sel, output logic [15:0] d);
		@(negedge clk_i);
		word_sel_o = sel;
		@(posedge clk_i);
		@(negedge clk_i);
		d = word_i;
	endtask
endmodule // asw_host_model
`default_nettype wire

// file: dv/asw_reporter_bench.sv
// Testbench for the axis status word reporter
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module asw_reporter_bench;
	logic        clk, rst_b, mv, inw, hd, hl, pe, pm, sv, flt;
	logic        emg, stb, ovl, merr, lok;
	logic [31:0] pos, z1l, z1h, z2l, z2h, pzl, pzh, cpw;
	logic [15:0] tgt, fcode, word, num, st, rd;
	logic [1:0]  sel;
	int          num_errors = 0;
	int          checked = 0;
	////////////////////////////////////////////////////////////////////////
	asw_reporter dut (.clk_i(clk), .rst_b_i(rst_b), .position_i(pos),
		.move_start_i(mv), .in_pos_width_i(inw), .target_num_i(tgt),
		.home_done_i(hd), .home_lost_i(hl), .push_end_i(pe),
		.push_miss_i(pm), .servo_on_i(sv), .fault_i(flt),
		.fault_code_i(fcode), .emg_stop_i(emg), .standby_i(stb),
		.overload_warn_i(ovl), .message_err_i(merr), .load_ok_i(lok),
		.first_range_flag_lo_i(z1l), .first_range_flag_hi_i(z1h), .second_range_flag_lo_i(z2l),
		.second_range_flag_hi_i(z2h), .entry_range_flag_lo_i(pzl), .entry_range_flag_hi_i(pzh),
		.word_sel_i(sel), .word_o(word), .current_position_word_o(cpw),
		.completed_position_number_o(num), .axis_status_flags_o(st));
	asw_host_model host (.clk_i(clk), .word_sel_o(sel), .word_i(word));
	////////////////////////////////////////////////////////////////////////
	// Free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// One registered cycle; inputs change on falling edges only
	task automatic step;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic end_sim;
		if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog: whole run is about 40 cycles
	initial begin
		#20000;
		num_errors++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////
	// Negative position crosses as two's complement, lo then hi word
	task automatic t_position;
		pos = -32'sd1023;
		step();
		`CHK(cpw, 32'hffff_fc01)
		host.read_word(2'h0, rd);
		`CHK(rd, 16'hfc01)
		host.read_word(2'h1, rd);
		`CHK(rd, 16'hffff)
		pos = 32'h0000_03ff;
		step();
		`CHK(cpw, 32'h0000_03ff)
	endtask
	// Plain move: number blank while moving, target shown at arrival
	task automatic t_move;
		sv = 1'b1;
		mv = 1'b1;
		step();
		mv = 1'b0;
		`CHK(num, 16'h0000)
		`CHK(st, 16'h0014)
		inw = 1'b1;
		tgt = 16'h0005;
		step();
		inw = 1'b0;
		`CHK(st, 16'h0111)
		`CHK(num, 16'h0005)
		host.read_word(2'h2, rd);
		`CHK(rd, 16'h0005)
	endtask
	// Pressing miss: end flag but no positioning done, number stays 0
	task automatic t_push;
		mv = 1'b1;
		step();
		mv = 1'b0;
		`CHK(st, 16'h0014)
		pe = 1'b1;
		pm = 1'b1;
		step();
		pe = 1'b0;
		pm = 1'b0;
		`CHK(st, 16'h0130)
		`CHK(num, 16'h0000)
		// Pressing that completes counts as positioning done
		mv = 1'b1;
		step();
		mv = 1'b0;
		pe = 1'b1;
		tgt = 16'h0007;
		step();
		pe = 1'b0;
		`CHK(num, 16'h0007)
		`CHK(st, 16'h0111)
		step();
		`CHK(st & 16'h0001, 16'h0001)
	endtask
	// Servo off drops motion end, done and servo flags
	task automatic t_servo;
		sv = 1'b0;
		step();
		`CHK(st & 16'h0111, 16'h0000)
		sv = 1'b1;
		step();
		`CHK(st & 16'h0010, 16'h0010)
	endtask
	// Homing sticks until home is lost or a fault; fault code replaces the number
	task automatic t_home_fault;
		hd = 1'b1;
		step();
		hd = 1'b0;
		step();
		`CHK(st & 16'h0102, 16'h0102)
		hl = 1'b1;
		step();
		hl = 1'b0;
		`CHK(st & 16'h0002, 16'h0000)
		hd = 1'b1;
		step();
		hd = 1'b0;
		`CHK(st & 16'h0002, 16'h0002)
		flt = 1'b1;
		fcode = 16'h0123;
		step();
		`CHK(num, 16'h0123)
		`CHK(st & 16'h000a, 16'h0008)
		flt = 1'b0;
		step();
		`CHK(st & 16'h0008, 16'h0000)
	endtask
	// Level flags, active high; unused bits stay zero
	task automatic t_levels;
		{emg, stb, ovl, lok} = 4'hf;
		step();
		`CHK(st & 16'hc6c0, 16'hc0c0)
		host.read_word(2'h3, rd);
		`CHK(rd & 16'hc6c0, 16'hc0c0)
		{emg, stb, ovl, lok, merr} = 5'h01;
		step();
		`CHK(st & 16'hc6c0, 16'h0080)
		merr = 1'b0;
		step();
		`CHK(st & 16'hc6c0, 16'h0000)
	endtask
	// Signed inclusive windows, boundary included
	task automatic t_zones;
		z1l = -32'sd100;
		z1h = 32'sd100;
		z2l = 32'sd200;
		z2h = 32'sd300;
		pzl = -32'sd20;
		pzh = -32'sd5;
		pos = -32'sd10;
		step();
		`CHK(st & 16'h3800, 16'h1800)
		pos = 32'sd250;
		step();
		`CHK(st & 16'h3800, 16'h2000)
		pos = 32'sd100;
		step();
		`CHK(st & 16'h3800, 16'h1000)
	endtask
	// Mid-run reset clears every word; number stays 0 until a move
	task automatic t_reset;
		rst_b = 1'b0;
		step();
		`CHK({cpw, num, st}, 64'h0)
		rst_b = 1'b1;
		step();
		`CHK(cpw, 32'h0000_0064)
		`CHK(num, 16'h0000)
		`CHK(st, 16'h1010)
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence; zones start empty (lo above hi)
	initial begin
		{rst_b, mv, inw, hd, hl, pe, pm, sv, flt} = 9'h0;
		{emg, stb, ovl, merr, lok} = 5'h0;
		{pos, tgt, fcode} = 64'h0;
		{z1l, z2l, pzl} = {3{32'h1}};
		{z1h, z2h, pzh} = 96'h0;
		repeat (6) @(negedge clk);
		`CHK({cpw, num, st}, 64'h0)
		rst_b = 1'b1;
		step();
		t_position();
		t_move();
		t_push();
		t_servo();
		t_home_fault();
		t_levels();
		t_zones();
		t_reset();
		end_sim();
	end
endmodule // asw_reporter_bench
`default_nettype wire
